// *** sdci_pkg.sv ***
package sdci_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_UNITS  = 5;
  localparam int unsigned ACC_W      = 20;
  localparam int unsigned CONV_W     = 12;
  localparam int unsigned DIGIT_W    = 4;
  localparam int unsigned CHAN_W     = 3;

  // ----------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ACC     = 8'h00;
  localparam logic [7:0] ADDR_INSTR   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_DONE    = 8'h0C;
  localparam logic [7:0] ADDR_OVF     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
  localparam logic [7:0] ADDR_DIST    = 8'h20;
  localparam logic [7:0] ADDR_CHANS   = 8'h24;

  // ----------------------------------------------------------------
  // instruction word fields: opcode [2:0], unit [6:4], offset j [9:8]
  // ----------------------------------------------------------------
  localparam int unsigned OP_LSB   = 0;
  localparam int unsigned UNIT_LSB = 4;
  localparam int unsigned J_LSB    = 8;

  typedef enum logic [2:0] {
    SDCI_OP_NONE = 3'h0,
    SDCI_OP_LSC  = 3'h1,
    SDCI_OP_BDN  = 3'h2,
    SDCI_OP_BOV  = 3'h3,
    SDCI_OP_RCV  = 3'h4,
    SDCI_OP_RDG  = 3'h5,
    SDCI_OP_LCV  = 3'h6
  } sdci_op_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned TICK_US        = 100;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DIST_MIN_US    = 3_200;
  localparam int unsigned DIST_MAX_US    = 102_400;
  localparam int unsigned DIST_MIN_TICKS = DIST_MIN_US / TICK_US;
  localparam int unsigned DIST_MAX_TICKS = DIST_MAX_US / TICK_US;
  localparam int unsigned DIST_W         = 11;
  localparam logic [DIST_W-1:0] DIST_RST = DIST_W'(DIST_MIN_TICKS);
  localparam logic [CHAN_W:0]   CHANS_RST = 4'h1;

endpackage

// *** sdci_unit_if.sv ***
interface sdci_unit_if;
  import sdci_pkg::*;
  logic              start;
  logic              step;
  logic              load_conv;
  logic [CONV_W-1:0] conv_wdata;
  logic [CONV_W-1:0] conv;
  logic              done_pulse;
  logic              ovf;

  modport ctrl (output start, step, load_conv, conv_wdata, input conv, done_pulse, ovf);
  modport unit (input start, step, load_conv, conv_wdata, output conv, done_pulse, ovf);
endinterface

// *** sdci_unit.sv ***
module sdci_unit
  import sdci_pkg::*;
#(
  parameter int unsigned CONV_CYC = 4
)
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // controller side
  sdci_unit_if.unit                bus,
  // timing and converter
  input  wire logic                tick_i,
  input  wire logic [DIST_W-1:0]   dist_ticks_i,
  input  wire logic [CHAN_W:0]     num_chans_i,
  input  wire logic [CONV_W-1:0]   adc_value_i,
  input  wire logic                adc_ovf_i
);

  typedef enum logic [1:0] {SDCI_IDLE, SDCI_CONV, SDCI_DIST} sdci_ust_e;

  sdci_ust_e         state_q;
  logic [DIST_W-1:0] cnt_q;
  logic [CONV_W-1:0] conv_q;
  logic              ovf_q;
  logic              done_q;
  logic [CHAN_W:0]   chan_q;

  wire multi  = num_chans_i > 4'h1;
  wire more   = multi && (chan_q + 4'h1 < num_chans_i);
  wire conv_e = (state_q == SDCI_CONV) && (cnt_q == DIST_W'(CONV_CYC));
  wire dist_e = (state_q == SDCI_DIST) && tick_i && (cnt_q + 11'h001 >= dist_ticks_i);

  assign bus.conv       = conv_q;
  assign bus.ovf        = ovf_q;
  assign bus.done_pulse = done_q;

  always_ff @(posedge clk_i)
  begin
    done_q <= 1'b0;
    if (rst_i)
    begin
      state_q <= SDCI_IDLE;
      cnt_q   <= '0;
      conv_q  <= '0;
      ovf_q   <= 1'b0;
      chan_q  <= '0;
    end
    else if (bus.start)
    begin
      // a new command aborts any distribution in progress
      state_q <= multi ? SDCI_CONV : SDCI_DIST;
      ovf_q   <= 1'b0;
      cnt_q   <= '0;
      chan_q  <= '0;
    end
    else if (bus.load_conv)
    begin
      conv_q <= bus.conv_wdata;
    end
    else if (bus.step && multi && more)
    begin
      chan_q  <= chan_q + 4'h1;
      state_q <= SDCI_CONV;
      cnt_q   <= '0;
    end
    else if (conv_e)
    begin
      conv_q  <= adc_value_i;
      ovf_q   <= ovf_q | adc_ovf_i;
      state_q <= SDCI_IDLE;
      done_q  <= 1'b1;
    end
    else if (state_q == SDCI_CONV)
    begin
      cnt_q <= cnt_q + 11'h001;
    end
    else if (dist_e)
    begin
      state_q <= SDCI_IDLE;
      done_q  <= 1'b1;
    end
    else if ((state_q == SDCI_DIST) && tick_i)
    begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

endmodule

// *** sdci_top.sv ***
module sdci_top
  import sdci_pkg::*;
#(
  parameter int unsigned UNITS    = NUM_UNITS,
  parameter int unsigned CONV_CYC = 4
)
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [7:0]                    adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // converter and decimal inputs from pins
  input  wire logic [UNITS*CONV_W-1:0]       adc_value_i,
  input  wire logic [UNITS-1:0]              adc_ovf_i,
  input  wire logic [2*DIGIT_W-1:0]          digits_i,
  // command registers towards the units' analog logic, and the interrupt output
  output logic      [UNITS*ACC_W-1:0]        cmd_o,
  output logic                               irq_o
);
  import sdci_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [UNITS*CONV_W-1:0] adc_m_q;
  logic [UNITS*CONV_W-1:0] adc_s_q;
  logic [UNITS-1:0]        ovf_m_q;
  logic [UNITS-1:0]        ovf_s_q;
  logic [2*DIGIT_W-1:0]    dig_m_q;
  logic [2*DIGIT_W-1:0]    dig_s_q;

  always_ff @(posedge clk_i)
  begin
    adc_m_q <= adc_value_i;
    adc_s_q <= adc_m_q;
    ovf_m_q <= adc_ovf_i;
    ovf_s_q <= ovf_m_q;
    dig_m_q <= digits_i;
    dig_s_q <= dig_m_q;
  end

  // ----------------------------------------------------------------
  // tick divider for distribution timing
  // ----------------------------------------------------------------
  logic [15:0] div_q;
  logic        tick_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (div_q == 16'(TICK_CYC - 1)))
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
    tick_q <= !rst_i && (div_q == 16'(TICK_CYC - 1));
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [ACC_W-1:0]  acc_q;
  logic [DIST_W-1:0] dist_q;
  logic [CHAN_W:0]   chans_q;
  logic [UNITS-1:0]  done_q;
  logic [UNITS-1:0]  irq_st_q;
  logic [UNITS-1:0]  irq_en_q;
  logic [1:0]        br_q;
  logic              br_valid_q;

  wire req      = cyc_i && stb_i && !ack_o;
  wire wr       = req && we_i && sel_i[0];
  wire wr_acc   = wr && (adr_i == ADDR_ACC);
  wire wr_instr = wr && (adr_i == ADDR_INSTR);
  wire wr_iclr  = wr && (adr_i == ADDR_IRQ_CLR);
  wire wr_ien   = wr && (adr_i == ADDR_IRQ_EN);
  wire wr_dist  = wr && (adr_i == ADDR_DIST);
  wire wr_chans = wr && (adr_i == ADDR_CHANS);

  wire [2:0] op   = dat_i[OP_LSB +: 3];
  wire [2:0] unum = dat_i[UNIT_LSB +: 3];
  wire [1:0] jofs = dat_i[J_LSB +: 2];
  // unit numbers run 1..UNITS; anything else addresses no unit
  wire       u_ok  = (unum != 3'h0) && (32'(unum) <= UNITS);
  wire [2:0] uidx  = unum - 3'h1;

  wire is_lsc = wr_instr && u_ok && (op == SDCI_OP_LSC);
  wire is_bdn = wr_instr && u_ok && (op == SDCI_OP_BDN);
  wire is_bov = wr_instr && u_ok && (op == SDCI_OP_BOV);
  wire is_rcv = wr_instr && u_ok && (op == SDCI_OP_RCV);
  wire is_rdg = wr_instr && (op == SDCI_OP_RDG);
  wire is_lcv = wr_instr && u_ok && (op == SDCI_OP_LCV);

  // ----------------------------------------------------------------
  // units
  // ----------------------------------------------------------------
  logic [UNITS-1:0]  done_ev;
  logic [UNITS-1:0]  ovf_w;
  logic [CONV_W-1:0] conv_w [UNITS];

  for (genvar g = 0; g < UNITS; g++)
  begin : g_unit
    sdci_unit_if uif ();
    wire sel = (uidx == 3'(g));

    assign uif.start      = is_lsc && sel;
    assign uif.step       = is_rcv && sel;
    assign uif.load_conv  = is_lcv && sel;
    assign uif.conv_wdata = acc_q[CONV_W-1:0];
    assign done_ev[g]     = uif.done_pulse;
    assign ovf_w[g]       = uif.ovf;
    assign conv_w[g]      = uif.conv;

    sdci_unit #(
      .CONV_CYC (CONV_CYC)
    ) u_unit (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .bus          (uif.unit),
      .tick_i       (tick_q),
      .dist_ticks_i (dist_q),
      .num_chans_i  (chans_q),
      .adc_value_i  (adc_s_q[g*CONV_W +: CONV_W]),
      .adc_ovf_i    (ovf_s_q[g])
    );

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cmd_o[g*ACC_W +: ACC_W] <= '0;
      end
      else if (is_lsc && sel)
      begin
        cmd_o[g*ACC_W +: ACC_W] <= acc_q;
      end
    end

    // the completion event wins over the clear from a new command
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        done_q[g]   <= 1'b0;
        irq_st_q[g] <= 1'b0;
      end
      else
      begin
        done_q[g]   <= done_ev[g] | (done_q[g] & !(is_lsc && sel));
        irq_st_q[g] <= done_ev[g] | (irq_st_q[g] & !(wr_iclr && dat_i[g]));
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator results
  // ----------------------------------------------------------------
  // conversion bits 1-12 land in acc bits 8-19, i.e. acc[11:0], msb first
  wire [ACC_W-1:0] rcv_val = {8'h00, conv_w[uidx]};
  // digit msb lands in the bit just below the sign, acc[18]; sign is acc[19]
  wire [ACC_W-1:0] rdg_val = {1'b0, dig_s_q, 11'h000};
  wire             cond_dn = done_q[uidx];
  wire             cond_ov = ovf_w[uidx];

  // acc bit 0 is the sign at acc[19]; both values are already in that order
  wire [ACC_W-1:0] acc_rev;
  for (genvar b = 0; b < ACC_W; b++)
  begin : g_rev
    assign acc_rev[b] = (is_rcv ? rcv_val[b] : rdg_val[b]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q      <= '0;
      br_q       <= '0;
      br_valid_q <= 1'b0;
      dist_q     <= DIST_RST;
      chans_q    <= CHANS_RST;
      irq_en_q   <= '0;
    end
    else
    begin
      if (wr_acc)
        acc_q <= dat_i[ACC_W-1:0];
      else if (is_rcv || is_rdg)
        acc_q <= acc_rev;
      if (is_bdn)
      begin
        br_q       <= cond_dn ? jofs : 2'h0;
        br_valid_q <= 1'b1;
      end
      else if (is_bov)
      begin
        br_q       <= cond_ov ? jofs : 2'h0;
        br_valid_q <= 1'b1;
      end
      if (wr_dist)
        dist_q <= (dat_i[DIST_W-1:0] < DIST_W'(DIST_MIN_TICKS)) ? DIST_W'(DIST_MIN_TICKS) :
                  (dat_i[DIST_W-1:0] > DIST_W'(DIST_MAX_TICKS)) ? DIST_W'(DIST_MAX_TICKS) :
                  dat_i[DIST_W-1:0];
      if (wr_chans && (dat_i[CHAN_W:0] != 4'h0) && (dat_i[CHAN_W:0] <= 4'h8))
        chans_q <= dat_i[CHAN_W:0];
      if (wr_ien)
        irq_en_q <= dat_i[UNITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (adr_i)
      ADDR_ACC:    rd_mux = 32'(acc_q);
      ADDR_STATUS: rd_mux = {29'h0000_0000, br_valid_q, br_q};
      ADDR_DONE:   rd_mux = 32'(done_q);
      ADDR_OVF:    rd_mux = 32'(ovf_w);
      ADDR_IRQ_ST: rd_mux = 32'(irq_st_q);
      ADDR_IRQ_EN: rd_mux = 32'(irq_en_q);
      ADDR_DIST:   rd_mux = 32'(dist_q);
      ADDR_CHANS:  rd_mux = 32'(chans_q);
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      ack_o <= req;
      dat_o <= req ? rd_mux : 32'h0000_0000;
      irq_o <= |(irq_st_q & irq_en_q);
    end
  end

endmodule

// *** sdci_props.sv ***
module sdci_props
  import sdci_pkg::*;
#(
  parameter int unsigned UNITS = NUM_UNITS
)
(
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // wishbone
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   we_i,
  input wire logic [7:0]             adr_i,
  input wire logic [3:0]             sel_i,
  input wire logic [31:0]            dat_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   ack_o,
  // pins
  input wire logic [UNITS*ACC_W-1:0] cmd_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req_w = cyc_i & stb_i & ~ack_o;
  wire rd_w  = req_w & ~we_i;
  wire wr_w  = cyc_i & stb_i & we_i;
  wire lsc_w = wr_w & sel_i[0] & (adr_i == ADDR_INSTR) & (dat_i[2:0] == SDCI_OP_LSC);

  property p_ack_follows; req_w |=> ack_o; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
  property p_ack_single; ack_o |=> !ack_o; endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack too long");
  property p_ack_cause; ack_o |-> $past(req_w); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // command outputs move only through a load-command instruction
  property p_cmd_cause;
    $changed(cmd_o) |-> $past(lsc_w, 1) || $past(lsc_w, 2) || $past(lsc_w, 3);
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("command changed alone");
  property p_irq_fall; $fell(irq_o) |-> $past(wr_w, 1) || $past(wr_w, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
  property p_unmapped; ack_o && $past(rd_w && adr_i > 8'h24) |-> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_w; ack_o && $past(rd_w && adr_i == ADDR_STATUS) |-> dat_o[31:3] == '0;
  endproperty
  a_status_w: assert property (p_status_w) else $error("status too wide");
  property p_acc_w; ack_o && $past(rd_w && adr_i == ADDR_ACC) |-> dat_o[31:ACC_W] == '0;
  endproperty
  a_acc_w: assert property (p_acc_w) else $error("accumulator too wide");
  property p_done_w; ack_o && $past(rd_w && adr_i == ADDR_DONE) |-> dat_o[31:UNITS] == '0;
  endproperty
  a_done_w: assert property (p_done_w) else $error("done flags too wide");
endmodule

bind sdci_top sdci_props #(.UNITS(UNITS)) u_sdci_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .cmd_o(cmd_o), .irq_o(irq_o));

// *** sdci_far_model.sv ***
module sdci_far_model
  import sdci_pkg::*;
#(
  parameter int unsigned UNITS = NUM_UNITS
)
(
  // clock and bench requests
  input  wire logic                    clk_i,
  input  wire logic                    refresh_i,
  input  wire logic [UNITS-1:0]        ovf_i,
  // converter and switch pins
  output logic      [UNITS*CONV_W-1:0] adc_value_o,
  output logic      [UNITS-1:0]        adc_ovf_o,
  output logic      [2*DIGIT_W-1:0]    digits_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 20;
  initial
  begin
    adc_value_o = '0;
    adc_ovf_o = '0;
    digits_o = 8'h00;
  end
  // values move only on request so the bench can predict each reading
  always @(posedge clk_i)
  begin
    adc_ovf_o <= ovf_i;
    if (refresh_i)
    begin
      for (int g = 0; g < UNITS; g++)
        adc_value_o[g*CONV_W +: CONV_W] <= CONV_W'($random(seed));
      digits_o <= {4'($unsigned($random(seed)) % 10), 4'($unsigned($random(seed)) % 10)};
    end
  end
endmodule

// *** tb.sv ***
module tb;
  import sdci_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i, cyc_i, stb_i, we_i, refresh, ovfb;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rdat, a;
  logic ack_o, irq_o;
  logic [4:0] ovf_req;
  logic [5*ACC_W-1:0] cmd_o, snap;
  wire logic [5*CONV_W-1:0] adc_value_i;
  wire logic [4:0] adc_ovf_i;
  wire logic [7:0] digits_i;
  int fail_count = 0;
  int tests_run = 0;
  integer seed = 20;

  sdci_top #(.CONV_CYC(40)) u_sdci_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .adc_value_i(adc_value_i), .adc_ovf_i(adc_ovf_i), .digits_i(digits_i),
    .cmd_o(cmd_o), .irq_o(irq_o));
  sdci_far_model u_sdci_far_model (.clk_i(clk_i), .refresh_i(refresh), .ovf_i(ovf_req),
    .adc_value_o(adc_value_i), .adc_ovf_o(adc_ovf_i), .digits_o(digits_i));

  initial forever #12.5 clk_i = ~clk_i;

  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after an edge; holds the cycle until ack, then idles one cycle
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    sel_i <= 4'hf;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1)
        break;
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (i == 50)
    begin
      fail_count++;
      conclude();
    end
    @(posedge clk_i);
  endtask

  task rd(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0000_0000);
  endtask

  task ex(input logic [2:0] op, input int k, input logic [1:0] j);
    bus(1'b1, ADDR_INSTR, {22'h00_0000, j, 1'b0, 3'(k), 1'b0, op});
  endtask

  task poll(input logic [7:0] ad, input int b);
    int i;
    for (i = 0; i < 100; i++)
    begin
      rd(ad);
      if (rdat[b] === 1'b1)
        break;
    end
    if (i == 100)
    begin
      fail_count++;
      conclude();
    end
  endtask

  task pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  function logic [31:0] st(input logic t, input logic [1:0] j);
    return {29'h0, 1'b1, t ? j : 2'b00};
  endfunction

  function logic [31:0] rcv_exp(input logic [11:0] v);
    return {20'h0_0000, v};
  endfunction

  function logic [31:0] rdg_exp(input logic [7:0] d);
    return {13'h0000, d, 11'h000};
  endfunction

  initial
  begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = '0;
    refresh = 1'b1;
    ovf_req = 5'h00;
    pause(10);
    rst_i <= 1'b0;
    refresh <= 1'b0;
    @(posedge clk_i);
    rd(8'h30);
    chk(rdat, 32'h0000_0000);
    bus(1'b1, ADDR_DIST, 32'h0000_0000);
    rd(ADDR_DIST);
    chk(rdat, 32'h0000_0020);
    bus(1'b1, ADDR_DIST, 32'h0000_07d0);
    rd(ADDR_DIST);
    chk(rdat, 32'h0000_0400);
    bus(1'b1, ADDR_CHANS, 32'h0000_0002);
    bus(1'b1, ADDR_IRQ_EN, 32'h0000_0000);
    for (int k = 1; k <= 5; k++)
    begin
      a = {12'h000, 20'($random(seed))};
      bus(1'b1, ADDR_ACC, a);
      ex(SDCI_OP_LCV, k, 2'd0);
      rd(ADDR_ACC);
      chk(rdat, a);
      ex(SDCI_OP_RCV, k, 2'd0);
      rd(ADDR_ACC);
      chk(rdat, rcv_exp(a[11:0]));
    end
    for (int k = 1; k <= 5; k++)
    begin
      a = {12'h000, 20'($random(seed))};
      ovfb = 1'($random(seed));
      ovf_req[k-1] <= ovfb;
      refresh <= 1'b1;
      @(posedge clk_i);
      refresh <= 1'b0;
      bus(1'b1, ADDR_ACC, a);
      ex(SDCI_OP_LSC, k, 2'd0);
      pause(2);
      chk(cmd_o[(k-1)*ACC_W +: ACC_W], a[19:0]);
      rd(ADDR_ACC);
      chk(rdat, a);
      ex(SDCI_OP_BDN, k, 2'd2);
      rd(ADDR_STATUS);
      chk(rdat, st(1'b0, 2'd2));
      poll(ADDR_DONE, k - 1);
      ex(SDCI_OP_BDN, k, 2'd2);
      rd(ADDR_STATUS);
      chk(rdat, st(1'b1, 2'd2));
      ex(SDCI_OP_BOV, k, 2'd1);
      rd(ADDR_STATUS);
      chk(rdat, st(ovfb, 2'd1));
      if (k == 1)
      begin
        chk(irq_o, 1'b0);
        bus(1'b1, ADDR_IRQ_EN, 32'h0000_001f);
      end
      pause(2);
      chk(irq_o, 1'b1);
      bus(1'b1, ADDR_IRQ_CLR, 32'h0000_001f);
      pause(2);
      chk(irq_o, 1'b0);
      ex(SDCI_OP_RCV, k, 2'd0);
      rd(ADDR_ACC);
      chk(rdat, rcv_exp(adc_value_i[(k-1)*CONV_W +: CONV_W]));
      poll(ADDR_IRQ_ST, k - 1);
      ovf_req[k-1] <= 1'b0;
      pause(4);
      ex(SDCI_OP_LSC, k, 2'd0);
      ex(SDCI_OP_BOV, k, 2'd1);
      rd(ADDR_STATUS);
      chk(rdat, st(1'b0, 2'd1));
      rd(ADDR_DONE);
      chk(rdat[k-1], 1'b0);
    end
    // the decimal read is issued only once a done test has succeeded
    poll(ADDR_DONE, 4);
    ex(SDCI_OP_RDG, 0, 2'd0);
    rd(ADDR_ACC);
    chk(rdat, rdg_exp(digits_i));
    snap = cmd_o;
    bus(1'b1, ADDR_ACC, 32'h000a_5a5a);
    ex(SDCI_OP_LSC, 0, 2'd0);
    ex(SDCI_OP_LSC, 6, 2'd0);
    pause(2);
    chk(cmd_o === snap, 1'b1);
    conclude();
  end
endmodule
